// ---- pkg/evstat_consts.svh ----
// Overview of operation
// - only enabled functions may trigger the fifo
// - trigger bits 5,4,3,2, reset to zero
// - trigger indications set on rising edge
// - gate error set on error, cleared when empty
// - five-bit odr count since gate error
// - source bits set on rising edge, read clears
// - bit 7 autosleep event, mode read clears
// - wake to sleep after inactivity limit
// - sleep to wake on selected wake event
// - bit 6 fifo overflow or watermark, status read clears
// - bit 5 transient active, its source read clears
// - bit 4 orientation changed, status read clears
// - bit 3 pulse active, its source read clears
// - bit 2 freefall motion, its source read clears
// - bit 0 data ready, cleared by xyz read
// - system mode register is read only
// - trigger mode stores 32 minus watermark more
// - fifo bit sets again on next sample
`ifndef EVSTAT_CONSTS_SVH
`define EVSTAT_CONSTS_SVH
`define ADDR_TRIG_SELECT 8'h0a
`define ADDR_SYSTEM_MODE 8'h0b
`define ADDR_INT_SOURCE 8'h0c
`define TRIG_MASK 8'h3c
`define BIT_TRANS 5
`define BIT_ORIENT 4
`define BIT_PULSE 3
`define BIT_FFMT 2
`define BIT_FIFO 6
`define BIT_ASLP 7
`define BIT_DRDY 0
`define BIT_GATE_ERR 7
`define TRIG_RESET 8'h00
`define FIFO_DEPTH 6'h20
`define FIFO_MODE_TRIGGER 2'h3
`endif

// ---- pkg/evstat_pkg.sv ----
package evstat_pkg;
  typedef enum logic [1:0] {
    MODE_STANDBY = 2'h0,
    MODE_WAKE = 2'h1,
    MODE_SLEEP = 2'h2
  } sys_mode_t;
  typedef enum {TRIG_IDLE, TRIG_ARMED, TRIG_POST, TRIG_DONE} trig_state_t;
endpackage : evstat_pkg

// ---- hw/edge_flag.sv ----
`timescale 1ns/1ps
`default_nettype none
// sticky flag: rising edge of the event sets, clear pulse clears, set wins
module edge_flag (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic event_level,
  input wire logic clear,
  output logic flag
);
  logic prev;

  // remember last level so only a low-to-high change counts
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      prev <= 1'b0;
    end else if (clk_en) begin
      prev <= event_level;
    end
  end

  // set beats clear so an edge landing on the read is kept
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      flag <= 1'b0;
    end else if (clk_en) begin
      if (event_level && !prev) begin
        flag <= 1'b1;
      end else if (clear) begin
        flag <= 1'b0;
      end
    end
  end
endmodule : edge_flag
`default_nettype wire

// ---- hw/sleep_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
// counts odr ticks without any interrupt; pulses when the limit is passed
module sleep_timer #(
  parameter int CW = 8
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic run,
  input wire logic activity,
  input wire logic odr_tick,
  input wire logic [CW-1:0] limit,
  output logic expired
);
  logic [CW:0] count;

  // counter is built for 1 to 16 bits only; refused at elaboration
  if (CW < 1 || CW > 16) begin : g_bad_cw
    $error("sleep_timer width out of range");
  end

  // strictly more than the limit, compared against the count before this tick's increment
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      count <= '0;
      expired <= 1'b0;
    end else if (clk_en) begin
      expired <= 1'b0;
      if (!run || activity) begin
        count <= '0;
      end else if (odr_tick) begin
        if (count > {1'b0, limit}) begin
          expired <= 1'b1;
          count <= '0;
        end else begin
          count <= count + {{CW{1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule : sleep_timer
`default_nettype wire

// ---- hw/accel_event_status_logic.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "evstat_consts.svh"
// event status block: trigger select, system mode, interrupt source
module accel_event_status_logic #(
  parameter int LIMIT_W = 8
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // register port, on the internal clock
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // events from detection functions and data path (same clock)
  input wire logic odr_tick,
  input wire logic active_req,
  input wire logic transient_event_active,
  input wire logic orientation_changed_flag,
  input wire logic pulse_event_active,
  input wire logic freefall_motion_event_active,
  input wire logic xyz_new_data_flag,
  input wire logic xyz_overrun_flag,
  input wire logic fifo_overflow,
  input wire logic [5:0] fifo_sample_count,
  input wire logic [5:0] fifo_watermark_level,
  input wire logic [1:0] fifo_mode,
  input wire logic fifo_sample_in,
  input wire logic gate_error_detect,
  // interrupt enables and wake sources from control registers
  input wire logic [7:0] int_enable,
  input wire logic [7:0] wake_source_enable,
  input wire logic autosleep_enable,
  input wire logic [LIMIT_W-1:0] inactivity_count_limit,
  // source register reads elsewhere in the map
  input wire logic rd_transient_source_register,
  input wire logic rd_orientation_status_register,
  input wire logic rd_pulse_source_register,
  input wire logic rd_freefall_motion_source_register,
  input wire logic rd_fifo_status,
  input wire logic rd_xyz_data,
  // outputs
  output logic fifo_trigger_event,
  output logic fifo_accept_stop,
  output logic high_odr_select,
  output logic [1:0] system_mode_out
);
  logic [7:0] fifo_trigger_select;
  evstat_pkg::sys_mode_t mode;
  logic gate_error_flag;
  logic [4:0] gate_error_period_count;
  logic autosleep_event_flag;
  logic fifo_event_flag;
  logic [5:0] src_flags;
  logic [7:0] interrupt_source_status;
  logic [7:0] system_mode_status;
  logic rd_system_mode_status;
  logic rd_intsrc;
  logic fifo_cond;
  logic fifo_cond_q;
  logic sleep_expired;
  logic wake_event;
  logic activity;
  logic [3:0] trig_prev;
  logic trig_edge;
  logic [5:0] post_count;
  evstat_pkg::trig_state_t trig_state;

  // inactivity limit is built for 1 to 16 bits only; refused at elaboration
  if (LIMIT_W < 1 || LIMIT_W > 16) begin : g_bad_limit_w
    $error("LIMIT_W out of range");
  end

  function automatic logic [7:0] read_mux(input logic [7:0] a, input logic [7:0] t,
                                          input logic [7:0] m, input logic [7:0] s);
    case (a)
      `ADDR_TRIG_SELECT: read_mux = t;
      `ADDR_SYSTEM_MODE: read_mux = m;
      `ADDR_INT_SOURCE: read_mux = s;
      default: read_mux = 8'h00;
    endcase
  endfunction : read_mux

  assign rd_system_mode_status = reg_rd && (reg_addr == `ADDR_SYSTEM_MODE);
  assign rd_intsrc = reg_rd && (reg_addr == `ADDR_INT_SOURCE);

  // trigger select: only defined bits are writable
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      fifo_trigger_select <= `TRIG_RESET;
    end else if (clk_en && reg_wr && reg_addr == `ADDR_TRIG_SELECT) begin
      fifo_trigger_select <= reg_wdata & `TRIG_MASK;
    end
  end

  // per-function sticky source bits, each cleared by its own source read
  edge_flag u_trans (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
    .event_level(transient_event_active && int_enable[`BIT_TRANS]),
    .clear(rd_transient_source_register), .flag(src_flags[`BIT_TRANS]));
  edge_flag u_orient (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
    .event_level(orientation_changed_flag && int_enable[`BIT_ORIENT]),
    .clear(rd_orientation_status_register), .flag(src_flags[`BIT_ORIENT]));
  edge_flag u_pulse (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
    .event_level(pulse_event_active && int_enable[`BIT_PULSE]),
    .clear(rd_pulse_source_register), .flag(src_flags[`BIT_PULSE]));
  edge_flag u_ffmt (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
    .event_level(freefall_motion_event_active && int_enable[`BIT_FFMT]),
    .clear(rd_freefall_motion_source_register), .flag(src_flags[`BIT_FFMT]));
  // status register read at 0x00 is not wired here, only the xyz data read
  edge_flag u_drdy (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
    .event_level((xyz_new_data_flag || xyz_overrun_flag) && int_enable[`BIT_DRDY]),
    .clear(rd_xyz_data), .flag(src_flags[`BIT_DRDY]));
  assign src_flags[1] = 1'b0;

  // fifo flag: rising edge, or a new sample while the condition holds
  assign fifo_cond = int_enable[`BIT_FIFO] && (fifo_overflow ||
    (fifo_watermark_level != 6'h00 && fifo_sample_count >= fifo_watermark_level));
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      fifo_cond_q <= 1'b0;
      fifo_event_flag <= 1'b0;
    end else if (clk_en) begin
      fifo_cond_q <= fifo_cond;
      if ((fifo_cond && !fifo_cond_q) || (fifo_cond && fifo_sample_in)) begin
        fifo_event_flag <= 1'b1;
      end else if (rd_fifo_status) begin
        fifo_event_flag <= 1'b0;
      end
    end
  end

  // trigger edges of enabled functions only
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      trig_prev <= 4'h0;
    end else if (clk_en) begin
      trig_prev <= {transient_event_active, orientation_changed_flag,
                    pulse_event_active, freefall_motion_event_active};
    end
  end
  assign trig_edge = |(fifo_trigger_select[5:2] & {transient_event_active,
    orientation_changed_flag, pulse_event_active, freefall_motion_event_active}
    & ~trig_prev);

  // trigger mode sequencing: after the trigger take 32 minus watermark samples
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      trig_state <= evstat_pkg::TRIG_IDLE;
      post_count <= 6'h00;
      fifo_trigger_event <= 1'b0;
      fifo_accept_stop <= 1'b0;
    end else if (clk_en) begin
      fifo_trigger_event <= 1'b0;
      case (trig_state)
        evstat_pkg::TRIG_IDLE: begin
          fifo_accept_stop <= 1'b0;
          if (fifo_mode == `FIFO_MODE_TRIGGER) trig_state <= evstat_pkg::TRIG_ARMED;
        end
        evstat_pkg::TRIG_ARMED: begin
          if (fifo_mode != `FIFO_MODE_TRIGGER) begin
            trig_state <= evstat_pkg::TRIG_IDLE;
          end else if (trig_edge) begin
            fifo_trigger_event <= 1'b1;
            post_count <= `FIFO_DEPTH - fifo_watermark_level;
            trig_state <= evstat_pkg::TRIG_POST;
          end
        end
        evstat_pkg::TRIG_POST: begin
          if (fifo_mode != `FIFO_MODE_TRIGGER) begin
            trig_state <= evstat_pkg::TRIG_IDLE;
          end else if (post_count == 6'h00) begin
            fifo_accept_stop <= 1'b1;
            trig_state <= evstat_pkg::TRIG_DONE;
          end else if (fifo_sample_in) begin
            post_count <= post_count - 6'h01;
          end
        end
        evstat_pkg::TRIG_DONE: begin
          if (fifo_mode != `FIFO_MODE_TRIGGER) trig_state <= evstat_pkg::TRIG_IDLE;
        end
        default: trig_state <= evstat_pkg::TRIG_IDLE;
      endcase
    end
  end

  // auto sleep / wake
  // pending function or fifo flags keep the device awake; data ready is left out
  // since it fires every sample and would keep the device from ever sleeping
  assign activity = (|src_flags[5:2]) || fifo_event_flag;
  assign wake_event = |({transient_event_active, orientation_changed_flag,
    pulse_event_active, freefall_motion_event_active, fifo_cond}
    & {wake_source_enable[5:2], wake_source_enable[6]});
  sleep_timer #(.CW(LIMIT_W)) u_sleep (.sys_clk(sys_clk), .rst_n(rst_n),
    .clk_en(clk_en), .run(autosleep_enable && mode == evstat_pkg::MODE_WAKE),
    .activity(activity || wake_event), .odr_tick(odr_tick),
    .limit(inactivity_count_limit), .expired(sleep_expired));

  // mode register state is never written by the host bus
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      mode <= evstat_pkg::MODE_STANDBY;
      autosleep_event_flag <= 1'b0;
    end else if (clk_en) begin
      if (!active_req) begin
        mode <= evstat_pkg::MODE_STANDBY;
      end else if (mode == evstat_pkg::MODE_STANDBY) begin
        mode <= evstat_pkg::MODE_WAKE;
      end else if (mode == evstat_pkg::MODE_WAKE && sleep_expired) begin
        mode <= evstat_pkg::MODE_SLEEP;
      end else if (mode == evstat_pkg::MODE_SLEEP && wake_event) begin
        mode <= evstat_pkg::MODE_WAKE;
      end
      if ((mode == evstat_pkg::MODE_WAKE && sleep_expired) ||
          (mode == evstat_pkg::MODE_SLEEP && wake_event && active_req)) begin
        autosleep_event_flag <= 1'b1;
      end else if (rd_system_mode_status) begin
        autosleep_event_flag <= 1'b0;
      end
    end
  end

  // gate error and the odr period count that follows it
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      gate_error_flag <= 1'b0;
      gate_error_period_count <= 5'h00;
    end else if (clk_en) begin
      if (gate_error_detect) begin
        gate_error_flag <= 1'b1;
      end else if (fifo_sample_count == 6'h00) begin
        gate_error_flag <= 1'b0;
      end
      if (!gate_error_flag) begin
        gate_error_period_count <= 5'h00;
      end else if (odr_tick && gate_error_period_count != 5'h1f) begin
        gate_error_period_count <= gate_error_period_count + 5'h01;
      end
    end
  end

  assign interrupt_source_status = {autosleep_event_flag, fifo_event_flag,
    src_flags[5:2], 1'b0, src_flags[0]};
  assign system_mode_status = {gate_error_flag, gate_error_period_count, mode};

  // registered read data and status outputs
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
      high_odr_select <= 1'b0;
      system_mode_out <= 2'h0;
    end else if (clk_en) begin
      reg_rdata <= read_mux(reg_addr, fifo_trigger_select, system_mode_status,
                            interrupt_source_status);
      high_odr_select <= (mode == evstat_pkg::MODE_WAKE);
      system_mode_out <= mode;
    end
  end

  // checks on what this block drives; causes that legally move the mode byte are excluded
  AST_SYSTEM_MODE_STATUS_RO: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && reg_wr && reg_addr == `ADDR_SYSTEM_MODE && !gate_error_detect && !odr_tick
     && active_req == (mode != evstat_pkg::MODE_STANDBY) && !sleep_expired && !wake_event
     && !(gate_error_flag && fifo_sample_count == 6'h00))
    |=> $stable(system_mode_status))
    else $error("mode register changed by write");
  AST_TRIG_MASK: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (fifo_trigger_select & ~`TRIG_MASK) == 8'h00)
    else $error("reserved trigger bits set");
  AST_TRIG_GATED: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (fifo_trigger_event && $past(clk_en)) |-> $past(trig_edge))
    else $error("trigger without enabled edge");
  AST_TRIG_ARM: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && trig_state == evstat_pkg::TRIG_ARMED && fifo_mode == `FIFO_MODE_TRIGGER
     && trig_edge) |=> fifo_trigger_event)
    else $error("enabled trigger edge lost");
  AST_GATE_SET: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && gate_error_detect) |=> gate_error_flag)
    else $error("gate error not flagged");
  AST_GATE_COUNT: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && !gate_error_flag) |=> gate_error_period_count == 5'h00)
    else $error("gate count not reset");
  AST_ASLP_CLR: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && rd_system_mode_status && !sleep_expired && !wake_event) |=> !autosleep_event_flag)
    else $error("autosleep flag not cleared");
  AST_FIFO_RESET: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && fifo_cond && fifo_sample_in) |=> fifo_event_flag)
    else $error("fifo flag not set on sample");
  AST_SLEEP: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && active_req && mode == evstat_pkg::MODE_WAKE && sleep_expired)
    |=> mode == evstat_pkg::MODE_SLEEP ##1 !high_odr_select)
    else $error("no wake to sleep");
  AST_WAKE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && active_req && mode == evstat_pkg::MODE_SLEEP && wake_event)
    |=> mode == evstat_pkg::MODE_WAKE)
    else $error("no sleep to wake");
  AST_DRDY_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && src_flags[`BIT_DRDY] && !rd_xyz_data) |=> src_flags[`BIT_DRDY])
    else $error("data ready flag lost without xyz read");
  AST_STOP_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && trig_state == evstat_pkg::TRIG_DONE && fifo_mode == `FIFO_MODE_TRIGGER)
    |=> fifo_accept_stop)
    else $error("fifo stop dropped in trigger mode");
  AST_MODE_CODE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    system_mode_out != 2'h3)
    else $error("illegal mode code");
  // main scenarios worth seeing at least once
  COV_SLEEP: cover property (@(posedge sys_clk) mode == evstat_pkg::MODE_SLEEP);
  COV_TRIG: cover property (@(posedge sys_clk) fifo_accept_stop);
  COV_GATE: cover property (@(posedge sys_clk) gate_error_period_count == 5'h03);
  COV_WAKE: cover property (@(posedge sys_clk)
    mode == evstat_pkg::MODE_SLEEP ##1 mode == evstat_pkg::MODE_WAKE);
  COV_FIFO_AGAIN: cover property (@(posedge sys_clk)
    fifo_cond && fifo_sample_in && !fifo_event_flag);
endmodule : accel_event_status_logic
`default_nettype wire

// ---- verif/host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// host side of the register port: single-byte writes and reads
module host_model (
  input wire logic sys_clk,
  input wire logic [7:0] reg_rdata,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd
);
  // idle bus at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end

  // write strobe lasts one edge; data is scrambled after so stale bytes never pass
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    #1;
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(posedge sys_clk);
    #1;
    reg_wr = 1'b0;
    reg_wdata = ~v;
  endtask : wr

  // read data is registered at the taking edge, so it is settled just after it
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge sys_clk);
    #1;
    reg_rd = 1'b0;
    v = reg_rdata;
  endtask : rd
endmodule : host_model
`default_nettype wire

// ---- verif/tb_accel_event_status_logic.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_accel_event_status_logic;
  logic sys_clk = 1'b0;
  logic rst_n, clk_en, odr_tick, active_req, samp, gerr, aslp_en, fstop, ftrig, hodr;
  logic reg_wr, reg_rd;
  logic [7:0] ev, clr, int_en, wake_en, lim, addr, wdata, rdata, d, v;
  logic [5:0] cnt, wmrk;
  logic [1:0] fmode, mode;
  int err_count = 0;
  int tests_run = 0;
  int trig_seen = 0;
  int ins[7] = '{5, 4, 3, 2, 6, 0, 1};
  int outs[7] = '{5, 4, 3, 2, 6, 0, 0};

  // 100 MHz clock
  always #5 sys_clk = ~sys_clk;
  // counts trigger pulses handed to the fifo
  always @(posedge sys_clk) if (ftrig === 1'b1) trig_seen++;

  accel_event_status_logic #(.LIMIT_W(8)) dut_u (
    .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(addr), .reg_wr(reg_wr),
    .reg_wdata(wdata), .reg_rd(reg_rd), .reg_rdata(rdata), .odr_tick(odr_tick),
    .active_req(active_req), .transient_event_active(ev[5]),
    .orientation_changed_flag(ev[4]), .pulse_event_active(ev[3]),
    .freefall_motion_event_active(ev[2]), .xyz_new_data_flag(ev[0]),
    .xyz_overrun_flag(ev[1]), .fifo_overflow(ev[6]), .fifo_sample_count(cnt),
    .fifo_watermark_level(wmrk), .fifo_mode(fmode), .fifo_sample_in(samp),
    .gate_error_detect(gerr), .int_enable(int_en), .wake_source_enable(wake_en),
    .autosleep_enable(aslp_en), .inactivity_count_limit(lim),
    .rd_transient_source_register(clr[5]), .rd_orientation_status_register(clr[4]),
    .rd_pulse_source_register(clr[3]), .rd_freefall_motion_source_register(clr[2]),
    .rd_fifo_status(clr[6]), .rd_xyz_data(clr[0]), .fifo_trigger_event(ftrig),
    .fifo_accept_stop(fstop), .high_odr_select(hodr), .system_mode_out(mode)
  );

  host_model host (
    .sys_clk(sys_clk), .reg_rdata(rdata), .reg_addr(addr), .reg_wr(reg_wr),
    .reg_wdata(wdata), .reg_rd(reg_rd)
  );

  function automatic logic [7:0] exp_mode(input logic g, input logic [4:0] n,
                                          input logic [1:0] m);
    return {g, n, m};
  endfunction : exp_mode

  // samples still taken after the trigger for a given watermark
  function automatic int exp_post(input logic [5:0] w);
    return 32 - int'(w);
  endfunction : exp_post

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // every task returns just after an edge, so inputs never race the sampling edge
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : step

  task automatic tick();
    odr_tick = 1'b1;
    step(1);
    odr_tick = 1'b0;
    step(3);
  endtask : tick

  task automatic pulse(input int b);
    clr[b] = 1'b1;
    step(1);
    clr[b] = 1'b0;
    step(1);
  endtask : pulse

  task automatic stop_test();
    $display("mismatches %0d of %0d checks", err_count, tests_run);
    if (err_count == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test

  // watchdog: the sequence needs about 320 cycles
  initial begin
    #100000;
    err_count++;
    stop_test();
  end

  // main sequence
  initial begin
    rst_n = 1'b0; clk_en = 1'b1; odr_tick = 1'b0; active_req = 1'b0; samp = 1'b0;
    gerr = 1'b0; aslp_en = 1'b0; ev = 8'h00; clr = 8'h00; int_en = 8'h7d;
    wake_en = 8'h20; lim = 8'd3; cnt = 6'd0; wmrk = 6'd0; fmode = 2'h0;
    void'($urandom(25205));
    step(8);
    rst_n = 1'b1;
    for (int a = 10; a <= 12; a++) begin
      host.rd(8'(a), d);
      chk(d, 8'h00);
    end
    // random trigger bytes; only the four function bits may stick
    for (int k = 0; k < 8; k++) begin
      v = (k == 0) ? 8'hff : 8'($urandom);
      host.wr(8'h0a, v);
      host.rd(8'h0a, d);
      chk(d, v & 8'h3c);
    end
    host.wr(8'h0b, 8'hff);
    host.wr(8'h0c, 8'hff);
    host.rd(8'h0b, d);
    chk(d, 8'h00);
    host.rd(8'h0c, d);
    chk(d, 8'h00);
    // each source: set on rise when enabled, held through other reads, own read clears
    for (int en = 1; en >= 0; en--) begin
      int_en = en ? 8'h7d : 8'h00;
      for (int i = 0; i < 7; i++) begin
        ev[ins[i]] = 1'b1;
        step(2);
        host.rd(8'h00, d);
        host.rd(8'h0c, d);
        chk(d, en ? 8'h01 << outs[i] : 8'h00);
        pulse(outs[i]);
        host.rd(8'h0c, d);
        chk(d, 8'h00);
        if (outs[i] == 6) begin
          samp = 1'b1;
          step(1);
          samp = 1'b0;
          step(1);
          host.rd(8'h0c, d);
          chk(d, en ? 8'h40 : 8'h00);
          pulse(6);
        end
        ev[ins[i]] = 1'b0;
        step(1);
      end
    end
    int_en = 8'h7d;
    // armed trigger mode: a cleared select bit must block, a set one must fire
    fmode = 2'h3;
    wmrk = 6'd28;
    host.wr(8'h0a, 8'h00);
    trig_seen = 0;
    ev[5] = 1'b1;
    step(3);
    ev[5] = 1'b0;
    pulse(5);
    chk(8'(trig_seen), 8'h00);
    host.wr(8'h0a, 8'h20);
    trig_seen = 0;
    ev[5] = 1'b1;
    step(3);
    chk(8'(trig_seen), 8'h01);
    for (int k = 1; k <= 4; k++) begin
      samp = 1'b1;
      step(1);
      samp = 1'b0;
      step(2);
      chk({7'h0, fstop}, {7'h0, k == exp_post(wmrk)});
    end
    ev[5] = 1'b0;
    pulse(5);
    fmode = 2'h0;
    step(2);
    chk({7'h0, fstop}, 8'h00);
    // wake, then sleep after the inactivity limit, then wake on a selected event
    active_req = 1'b1;
    step(3);
    chk({6'h0, mode}, 8'h01);
    chk({7'h0, hodr}, 8'h01);
    aslp_en = 1'b1;
    repeat (3) tick();
    chk({6'h0, mode}, 8'h01);
    repeat (3) tick();
    chk({6'h0, mode}, 8'h02);
    chk({7'h0, hodr}, 8'h00);
    host.rd(8'h0c, d);
    chk(d, 8'h80);
    host.rd(8'h0b, d);
    chk(d, exp_mode(1'b0, 5'd0, 2'h2));
    host.rd(8'h0c, d);
    chk(d, 8'h00);
    ev[5] = 1'b1;
    step(3);
    chk({6'h0, mode}, 8'h01);
    host.rd(8'h0c, d);
    chk(d, 8'ha0);
    ev[5] = 1'b0;
    aslp_en = 1'b0;
    pulse(5);
    host.rd(8'h0b, d);
    chk(d, exp_mode(1'b0, 5'd0, 2'h1));
    host.rd(8'h0c, d);
    chk(d, 8'h00);
    // gate error: counts odr periods, ignores writes, clears once the fifo is empty
    cnt = 6'd5;
    gerr = 1'b1;
    step(1);
    gerr = 1'b0;
    step(1);
    repeat (3) tick();
    host.wr(8'h0b, 8'h00);
    host.rd(8'h0b, d);
    chk(d, exp_mode(1'b1, 5'd3, 2'h1));
    cnt = 6'd0;
    step(2);
    host.rd(8'h0b, d);
    chk(d, exp_mode(1'b0, 5'd0, 2'h1));
    // low enable freezes all state: an event edge and a gate error are both ignored
    clk_en = 1'b0;
    ev[5] = 1'b1;
    gerr = 1'b1;
    step(3);
    ev[5] = 1'b0;
    gerr = 1'b0;
    clk_en = 1'b1;
    step(1);
    host.rd(8'h0c, d);
    chk(d, 8'h00);
    host.rd(8'h0b, d);
    chk(d, exp_mode(1'b0, 5'd0, 2'h1));
    stop_test();
  end
endmodule : tb_accel_event_status_logic
`default_nettype wire
